// ===== swd_top.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module swd_top
  import swd_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_POS-1:0] sysrefTap,
  output logic stepFine,
  output logic receiverPowerdown,
  output logic [SEL_W-1:0] sampleSelectActive,
  output logic sysrefProcessed,
  output logic clockAlignPulse,
  output logic irq
);

  logic [CTL_W-1:0] ctrl;
  logic [SEL_W-1:0] sampleSelect;
  logic [NUM_POS-1:0] windowStatus;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic [NUM_POS-1:0] tapStable;
  logic [NUM_POS-1:0] tapPrev;
  logic [NUM_POS-1:0] tapFlags;
  logic stickyPrev;
  logic procPrev;
  logic selTapPrev;
  swd_proc_e procState;
  swd_proc_e next_procState;

  // Delayed sample points arrive from the analog delay row, unsynchronised
  swd_sync3 #(
    .WIDTH(NUM_POS)
  ) u_tap_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .din(sysrefTap),
    .dout(tapStable)
  );

  swd_window_eval #(
    .NUM(NUM_POS)
  ) u_eval (
    .taps(tapStable),
    .flags(tapFlags)
  );

  // Bus decode
  wire [9:0] regIdx = paddr[ADDR_W-1:2];
  wire hitLow = (regIdx == IDX_STATUS_LOW);
  wire hitMid = (regIdx == IDX_STATUS_MID);
  wire hitHigh = (regIdx == IDX_STATUS_HIGH);
  wire hitCtl = (regIdx == IDX_CONTROL);
  wire hitSel = (regIdx == IDX_SELECT);
  wire hitIrqSt = (regIdx == IDX_IRQ_STATUS);
  wire hitIrqMask = (regIdx == IDX_IRQ_MASK);
  wire mapped = hitLow | hitMid | hitHigh | hitCtl | hitSel | hitIrqSt
    | hitIrqMask;
  wire setupRead = psel & ~penable & ~pwrite;
  wire accessWrite = psel & penable & pwrite & mapped;
  wire wrCtl = accessWrite & hitCtl;
  wire wrSel = accessWrite & hitSel;
  wire wrIrqSt = accessWrite & hitIrqSt;
  wire wrIrqMask = accessWrite & hitIrqMask;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Read data is captured in the setup cycle so prdata comes from a flop
  wire [31:0] rdMux =
    hitLow ? {24'h000000, windowStatus[7:0]} :
    hitMid ? {24'h000000, windowStatus[15:8]} :
    hitHigh ? {28'h0000000, windowStatus[19:16]} :
    hitCtl ? {27'h0000000, ctrl} :
    hitSel ? {28'h0000000, sampleSelect} :
    hitIrqSt ? {30'h00000000, irqStatus} :
    hitIrqMask ? {30'h00000000, irqMask} :
    32'h00000000;

  // Control fields
  wire fineEn = ctrl[CTL_FINE];
  wire stickyEn = ctrl[CTL_STICKY];
  wire powerDown = ctrl[CTL_PDN];
  wire procEn = ctrl[CTL_PROC];
  wire alignEn = ctrl[CTL_ALIGN];

  assign stepFine = fineEn;
  assign receiverPowerdown = powerDown;

  // A measurement is taken on the first snapshot that shows SYSREF high
  // after one that showed it low at every point.
  wire measEdge = ~powerDown & (|tapStable) & ~(|tapPrev);
  wire stickyRise = stickyEn & ~stickyPrev;
  wire procRise = procEn & ~procPrev;

  // Restarting accumulation drops history but keeps the outer points set
  wire [NUM_POS-1:0] statusBase = stickyRise ? EDGE_FORCE : windowStatus;
  wire [NUM_POS-1:0] measured = tapFlags | EDGE_FORCE;
  wire [NUM_POS-1:0] next_windowStatus =
    !measEdge ? statusBase :
    stickyEn ? (statusBase | measured) :
    measured;

  // Processing at the active point
  wire selTap = tapStable[sampleSelectActive];
  wire selEdge = ~powerDown & selTap & ~selTapPrev;
  wire selViolation = measEdge & measured[sampleSelectActive]
    & (procState != PS_OFF);

  wire [IRQ_W-1:0] irqEvents;
  assign irqEvents[IRQ_MEASURE] = measEdge;
  assign irqEvents[IRQ_SELVIOL] = selViolation;
  wire [IRQ_W-1:0] irqClear = wrIrqSt ? pwdata[IRQ_W-1:0] : '0;
  // Set wins over a clear arriving in the same cycle
  wire [IRQ_W-1:0] next_irqStatus = (irqStatus & ~irqClear) | irqEvents;

  always_comb begin
    next_procState = procState;
    unique case (procState)
      PS_OFF: begin
        if (procEn && !powerDown) begin
          next_procState = PS_WAIT;
        end
      end
      PS_WAIT: begin
        if (!procEn || powerDown) begin
          next_procState = PS_OFF;
        end else if (alignEn && selEdge) begin
          next_procState = PS_RUN;
        end
      end
      PS_RUN: begin
        if (!procEn || powerDown) begin
          next_procState = PS_OFF;
        end
      end
      default: begin
        next_procState = PS_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTL_RESET;
      sampleSelect <= SEL_RESET;
      irqMask <= IRQ_MASK_RESET;
    end else begin
      if (wrCtl) begin
        ctrl <= pwdata[CTL_W-1:0];
      end
      if (wrSel) begin
        sampleSelect <= pwdata[SEL_W-1:0];
      end
      if (wrIrqMask) begin
        irqMask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (setupRead) begin
      prdata <= rdMux;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      windowStatus <= EDGE_FORCE;
      tapPrev <= '0;
      stickyPrev <= 1'b0;
    end else begin
      windowStatus <= next_windowStatus;
      tapPrev <= tapStable;
      stickyPrev <= stickyEn;
    end
  end

  // The select value is only taken when processing is switched on, so a
  // write while processing runs cannot shift the point mid-stream.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampleSelectActive <= SEL_RESET;
      procPrev <= 1'b0;
    end else begin
      procPrev <= procEn;
      if (procRise) begin
        sampleSelectActive <= sampleSelect;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      procState <= PS_OFF;
      selTapPrev <= 1'b0;
      sysrefProcessed <= 1'b0;
      clockAlignPulse <= 1'b0;
    end else begin
      procState <= next_procState;
      selTapPrev <= selTap;
      sysrefProcessed <= (procState == PS_RUN) & procEn & selEdge;
      clockAlignPulse <= (procState == PS_WAIT) & procEn & alignEn
        & selEdge;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      irq <= |(next_irqStatus & irqMask);
    end
  end

endmodule // swd_top

// ===== swd_pkg.sv
package swd_pkg;

  // Window geometry
  localparam int NUM_POS = 20;
  localparam int SEL_W = 4;
  localparam logic [19:0] EDGE_FORCE = 20'h80001;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_STATUS_LOW = 10'h090;
  localparam logic [9:0] IDX_STATUS_MID = 10'h091;
  localparam logic [9:0] IDX_STATUS_HIGH = 10'h092;
  localparam logic [9:0] IDX_CONTROL = 10'h093;
  localparam logic [9:0] IDX_SELECT = 10'h094;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h095;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h096;
  localparam int ADDR_W = 12;

  // Control register fields
  localparam int CTL_FINE = 0;
  localparam int CTL_STICKY = 1;
  localparam int CTL_PDN = 2;
  localparam int CTL_PROC = 3;
  localparam int CTL_ALIGN = 4;
  localparam int CTL_W = 5;
  localparam logic [4:0] CTL_RESET = 5'h05;
  localparam logic [3:0] SEL_RESET = 4'h0;

  // Interrupt events
  localparam int IRQ_MEASURE = 0;
  localparam int IRQ_SELVIOL = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Processing sequence
  typedef enum logic [1:0] {
    PS_OFF = 2'b00,
    PS_WAIT = 2'b01,
    PS_RUN = 2'b11
  } swd_proc_e;

endpackage

// ===== swd_sync3.sv
`timescale 1ns/1ps
module swd_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // A bit moves only once the last two stages agree
  wire [WIDTH-1:0] next_dout = (stage2 & stage3) | (dout & (stage2 | stage3));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout <= next_dout;
    end
  end
endmodule // swd_sync3

// ===== swd_window_eval.sv
`timescale 1ns/1ps
module swd_window_eval #(
  parameter int NUM = 20
) (
  input wire logic [NUM-1:0] taps,
  output logic [NUM-1:0] flags
);
  // A point next to a level change sits in the transition region
  genvar i;
  generate
    for (i = 0; i < NUM; i++) begin : g_pos
      if (i == 0 || i == NUM - 1) begin : g_edge
        assign flags[i] = 1'b1;
      end else begin : g_mid
        assign flags[i] = (taps[i] ^ taps[i-1]) | (taps[i] ^ taps[i+1]);
      end
    end
  endgenerate
endmodule // swd_window_eval

// ===== swd_top_sva.sv
`timescale 1ns/1ps
module swd_top_sva
  import swd_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stepFine,
  input wire logic receiverPowerdown,
  input wire logic sysrefProcessed,
  input wire logic clockAlignPulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire logic [9:0] idx = paddr[11:2];
  wire logic unmapped = idx < IDX_STATUS_LOW || idx > IDX_IRQ_MASK;
  wire logic setupRd = psel && !penable && !pwrite;
  wire logic ctlWr = psel && penable && pwrite && idx == IDX_CONTROL;
  ready_always_a: assert property (pready) else $error("pready low");
  err_decode_a: assert property (psel && penable |-> pslverr == unmapped)
    else $error("pslverr decode wrong");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  rdata_hold_a: assert property (!setupRd |=> $stable(prdata))
    else $error("prdata moved");
  unmapped_zero_a: assert property (setupRd && unmapped |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  status_top_a: assert property (setupRd && idx == IDX_STATUS_HIGH
    |=> prdata[31:4] == 28'h0) else $error("status high upper bits");
  fine_write_a: assert property (ctlWr |=> stepFine == $past(pwdata[0]))
    else $error("stepFine not written");
  align_once_a: assert property (clockAlignPulse |=> !clockAlignPulse)
    else $error("align pulse too long");
  pulse_excl_a: assert property (!(clockAlignPulse && sysrefProcessed))
    else $error("both pulses");
  pdn_freeze_a: assert property (receiverPowerdown &&
    $past(receiverPowerdown) |-> !sysrefProcessed && !clockAlignPulse)
    else $error("pulse while powered down");
  cover property (clockAlignPulse);
  cover property (sysrefProcessed);
  cover property (pslverr);
endmodule // swd_top_sva
bind swd_top swd_top_sva chk (.core_clk, .arst_n, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .stepFine,
  .receiverPowerdown, .sysrefProcessed, .clockAlignPulse);

// ===== swd_sysref_src.sv
`timescale 1ns/1ps
module swd_sysref_src (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [19:0] pattern,
  output logic [19:0] sysrefTap
);
  int hold = 0;
  always @(posedge core_clk) begin
    if (go) begin
      hold <= 8;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  // Idles low between edges so each edge is a clean rise
  assign sysrefTap = (hold > 0) ? pattern : 20'h0;
endmodule // swd_sysref_src

// ===== tb.sv
`timescale 1ns/1ps
module tb
  import swd_pkg::*;
;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, stepFine, pdn, proc, align, irq, srcGo = 1'b0;
  logic [19:0] tap, srcPat = '0;
  logic [SEL_W-1:0] sel;
  int fails = 0, check_count = 0, alignCount = 0, procCount = 0;
  always #25 core_clk = ~core_clk;
  swd_sysref_src src (.core_clk, .go(srcGo), .pattern(srcPat),
    .sysrefTap(tap));
  swd_top dut (.core_clk, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .sysrefTap(tap), .stepFine,
    .receiverPowerdown(pdn), .sampleSelectActive(sel),
    .sysrefProcessed(proc), .clockAlignPulse(align), .irq);
  always @(posedge core_clk) begin
    alignCount <= alignCount + align;
    procCount <= procCount + proc;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (n >= 20) begin
      fails++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [9:0] i, input logic [31:0] x);
    apb(1'b0, i, 32'h0);
    chk(n, q, x);
  endtask
  task automatic status(input string n, input logic [19:0] s);
    rd(n, IDX_STATUS_LOW, {24'h0, s[7:0]});
    rd(n, IDX_STATUS_MID, {24'h0, s[15:8]});
    rd(n, IDX_STATUS_HIGH, {28'h0, s[19:16]});
  endtask
  task automatic fire(input logic [19:0] p);
    @(posedge core_clk);
    srcPat <= p;
    srcGo <= 1'b1;
    @(posedge core_clk);
    srcGo <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    chk("powerdown", pdn, 1'b1);
    rd("control", IDX_CONTROL, 32'h5);
    rd("select", IDX_SELECT, 32'h0);
    rd("irq mask", IDX_IRQ_MASK, 32'h0);
    status("status reset", 20'h80001);
    rd("unmapped", 10'h3ff, 32'h0);
    chk("unmapped err", e, 1'b1);
    apb(1'b1, IDX_STATUS_LOW, 32'hff);
    status("status ro", 20'h80001);
    $display("test registers done");
    apb(1'b1, IDX_CONTROL, 32'h0);
    @(negedge core_clk);
    chk("coarse", stepFine, 1'b0);
    chk("powered up", pdn, 1'b0);
    apb(1'b1, IDX_CONTROL, 32'h1);
    @(negedge core_clk);
    chk("fine", stepFine, 1'b1);
    apb(1'b1, IDX_IRQ_MASK, 32'h1);
    fire(20'h000ff);
    status("window a", 20'h80181);
    chk("irq set", irq, 1'b1);
    apb(1'b1, IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(negedge core_clk);
    chk("irq clear", irq, 1'b0);
    apb(1'b1, IDX_IRQ_MASK, 32'h0);
    fire(20'h00fff);
    status("window b", 20'h81801);
    chk("irq masked", irq, 1'b0);
    rd("irq status", IDX_IRQ_STATUS, 32'h1);
    $display("test measure done");
    apb(1'b1, IDX_CONTROL, 32'h3);
    status("sticky restart", 20'h80001);
    fire(20'h000ff);
    fire(20'h00fff);
    status("sticky", 20'h81981);
    apb(1'b1, IDX_SELECT, 32'h1f);
    rd("select clip", IDX_SELECT, 32'hf);
    apb(1'b1, IDX_SELECT, 32'h3);
    apb(1'b1, IDX_CONTROL, 32'h19);
    fire(20'h000ff);
    chk("align", alignCount, 1);
    chk("active", sel, 4'h3);
    fire(20'h0000f);
    chk("processed", procCount, 1);
    status("window c", 20'h80019);
    rd("violation", IDX_IRQ_STATUS, 32'h3);
    apb(1'b1, IDX_SELECT, 32'h5);
    repeat (2) @(negedge core_clk);
    chk("held select", sel, 4'h3);
    apb(1'b1, IDX_CONTROL, 32'h11);
    apb(1'b1, IDX_CONTROL, 32'h19);
    repeat (2) @(negedge core_clk);
    chk("new select", sel, 4'h5);
    apb(1'b1, IDX_CONTROL, 32'h1d);
    @(negedge core_clk);
    chk("powered down", pdn, 1'b1);
    fire(20'h000ff);
    chk("frozen", alignCount + procCount, 2);
    $display("test processing done");
    stop_test();
  end
endmodule // tb
